// *** otgc_defs.svh ***
// otgc_defs.svh: offsets, field positions, reset values and timing for the otg control block
// assumes a 50 MHz system clock and byte offsets on an 8-bit register address
`ifndef OTGC_DEFS_SVH
`define OTGC_DEFS_SVH

`define OTGC_ADDR_W 8
`define OTGC_DATA_W 16

`define OTGC_ADDR_CTRL_SET 8'he4
`define OTGC_ADDR_CTRL_CLR 8'he6
`define OTGC_ADDR_SRC 8'he8

// control register field positions
`define OTGC_CTL_BUS_RST_EN 9
`define OTGC_CTL_AUTO_CONN_EN 8
`define OTGC_CTL_CTRL_SEL 7
`define OTGC_CTL_CHARGE 6
`define OTGC_CTL_DISCHARGE 5
`define OTGC_CTL_PWR_DRIVE 4
`define OTGC_CTL_DM_PD 2
`define OTGC_CTL_DP_PD 1
`define OTGC_CTL_DP_PU 0

`define OTGC_CTL_RESET 16'h0086
`define OTGC_CTL_MASK 16'h03f7

// event source register field positions
`define OTGC_SRC_P2_DP 11
`define OTGC_SRC_P2_A_SESS 10
`define OTGC_SRC_TMR 9
`define OTGC_SRC_SE0_IDLE 8
`define OTGC_SRC_B_SESSION_ENDED 7
`define OTGC_SRC_REMOTE_CONNECT_SEEN 4
`define OTGC_SRC_ID 3
`define OTGC_SRC_P1_DP 2
`define OTGC_SRC_P1_SESS 1
`define OTGC_SRC_P1_VBUS 0

`define OTGC_SRC_RESET 16'h1188
`define OTGC_SRC_FIXED 16'h1000

// timing
`define OTGC_CLK_MHZ 50
`define OTGC_SE0_IDLE_US 2000
`define OTGC_BUS_RESET_US 10000
`define OTGC_CNT_W 20

`endif

// *** otgc_pkg.sv ***
// otgc_pkg: types shared by the otg control block and its se0 idle timer
// assumes otgc_defs.svh is on the include path
package otgc_pkg;
    `include "otgc_defs.svh"

    typedef logic [`OTGC_DATA_W-1:0] otgc_word_t;
    typedef logic [`OTGC_CNT_W-1:0] otgc_cnt_t;

    typedef enum logic {
        OTGC_BR_IDLE,
        OTGC_BR_DRIVE
    } otgc_br_state_t;

    typedef struct packed {
        otgc_word_t ctrl;
        otgc_word_t src;
        otgc_word_t rdata;
        otgc_br_state_t br_state;
        otgc_cnt_t br_cnt;
        logic rmt_prev;
        logic port1_power;
        logic bdis_event;
    } otgc_top_state_t;

    typedef struct packed {
        otgc_cnt_t cnt;
        logic expired;
    } otgc_se0_state_t;
endpackage : otgc_pkg

// *** otgc_se0_if.sv ***
// otgc_se0_if: carries line se0 and b-idle into the idle timer and its expiry back out
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface otgc_se0_if;
    logic line_se0;
    logic b_idle;
    logic expired;
    modport timer (input line_se0, input b_idle, output expired);
    modport user (output line_se0, output b_idle, input expired);
endinterface : otgc_se0_if

// *** otgc_se0_timer.sv ***
// otgc_se0_timer: flags se0 that has persisted while the b-device is idle
// assumes inputs synchronous to clock; LIMIT is the persistence in cycles
`timescale 1ns/1ps
`include "otgc_defs.svh"
module otgc_se0_timer
    import otgc_pkg::*;
#(
    parameter int unsigned LIMIT = `OTGC_SE0_IDLE_US * `OTGC_CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst,
    otgc_se0_if.timer tif
);
    localparam otgc_cnt_t LAST = otgc_cnt_t'(LIMIT - 1);

    otgc_se0_state_t st_ff;
    otgc_se0_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!(tif.line_se0 && tif.b_idle)) begin
            nxt_st.cnt = '0;
            nxt_st.expired = 1'b0;
        end else if (st_ff.cnt == LAST) begin
            nxt_st.expired = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + otgc_cnt_t'(1);
        end
    end

    // reset state reads as expired so the source bit comes up set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '{cnt: LAST, expired: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tif.expired = st_ff.expired;
endmodule : otgc_se0_timer

// *** otgc_control.sv ***
// otgc_control: otg control register with set/clear addresses and live event source register
// assumes a single-cycle register port, pin levels synchronous to clock
`timescale 1ns/1ps
`include "otgc_defs.svh"
module otgc_control
    import otgc_pkg::*;
#(
    parameter int unsigned SE0_IDLE_CYCLES = `OTGC_SE0_IDLE_US * `OTGC_CLK_MHZ,
    parameter int unsigned BUS_RESET_CYCLES = `OTGC_BUS_RESET_US * `OTGC_CLK_MHZ
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`OTGC_ADDR_W-1:0] reg_addr,
    input wire logic [`OTGC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`OTGC_DATA_W-1:0] reg_rdata,
    input wire logic otg_mode,
    input wire logic hub_port1_power,
    input wire logic remote_connect_seen,
    input wire logic line_se0,
    input wire logic b_idle,
    input wire logic port2_plus_line_state,
    input wire logic port2_a_session_valid,
    input wire logic otg_timer_expired,
    input wire logic b_session_ended,
    input wire logic id_pin,
    input wire logic port1_plus_line_state,
    input wire logic port1_a_session_valid,
    input wire logic port1_b_session_valid,
    input wire logic port1_bus_power_valid,
    output logic controller_select,
    output logic bus_reset_drive,
    output logic bus_power_charge,
    output logic bus_power_discharge,
    output logic port1_power_drive,
    output logic minus_line_pull_down,
    output logic plus_line_pull_down,
    output logic plus_line_pull_up,
    output logic b_disconnect_a_connect_event
);
    localparam otgc_cnt_t BR_LAST = otgc_cnt_t'(BUS_RESET_CYCLES - 1);

    otgc_top_state_t st_ff;
    otgc_top_state_t nxt_st;
    otgc_se0_if se0_if ();

    assign se0_if.line_se0 = line_se0;
    assign se0_if.b_idle = b_idle;

    otgc_se0_timer #(
        .LIMIT(SE0_IDLE_CYCLES)
    ) u_se0_timer (
        .clock(clock),
        .rst(rst),
        .tif(se0_if.timer)
    );

    always_comb begin
        logic connect_rise;
        logic disconnect_fall;
        logic sess_valid;
        otgc_word_t src;
        connect_rise = 1'b0;
        disconnect_fall = 1'b0;
        sess_valid = 1'b0;
        src = `OTGC_SRC_FIXED;

        nxt_st = st_ff;
        nxt_st.rdata = '0;
        nxt_st.bdis_event = 1'b0;
        nxt_st.rmt_prev = remote_connect_seen;
        connect_rise = remote_connect_seen && !st_ff.rmt_prev;
        disconnect_fall = !remote_connect_seen && st_ff.rmt_prev;

        // software writes first so hardware sets below win a same-cycle clear
        if (reg_wr && reg_addr == `OTGC_ADDR_CTRL_SET) begin
            nxt_st.ctrl = st_ff.ctrl | (reg_wdata & `OTGC_CTL_MASK);
        end else if (reg_wr && reg_addr == `OTGC_ADDR_CTRL_CLR) begin
            nxt_st.ctrl = st_ff.ctrl & ~(reg_wdata & `OTGC_CTL_MASK);
        end

        // disconnect of the b-device with auto-connect enabled
        if (disconnect_fall && st_ff.ctrl[`OTGC_CTL_AUTO_CONN_EN]) begin
            nxt_st.bdis_event = 1'b1;
            nxt_st.ctrl[`OTGC_CTL_CTRL_SEL] = 1'b1;
            nxt_st.ctrl[`OTGC_CTL_DP_PU] = 1'b1;
        end

        // bus reset on remote connect while host is selected
        unique case (st_ff.br_state)
            OTGC_BR_IDLE: begin
                if (connect_rise && st_ff.ctrl[`OTGC_CTL_BUS_RST_EN]
                        && !st_ff.ctrl[`OTGC_CTL_CTRL_SEL]) begin
                    nxt_st.br_state = OTGC_BR_DRIVE;
                    nxt_st.br_cnt = '0;
                end
            end
            OTGC_BR_DRIVE: begin
                if (st_ff.br_cnt == BR_LAST || !remote_connect_seen) begin
                    nxt_st.br_state = OTGC_BR_IDLE;
                end else begin
                    nxt_st.br_cnt = st_ff.br_cnt + otgc_cnt_t'(1);
                end
            end
        endcase

        // port1 power follows the register only in otg mode
        nxt_st.port1_power = otg_mode ? nxt_st.ctrl[`OTGC_CTL_PWR_DRIVE]
                                      : hub_port1_power;

        // live source sample, refreshed every cycle, never held
        sess_valid = id_pin ? port1_b_session_valid : port1_a_session_valid;
        src[`OTGC_SRC_P2_DP] = port2_plus_line_state;
        src[`OTGC_SRC_P2_A_SESS] = port2_a_session_valid;
        src[`OTGC_SRC_TMR] = otg_timer_expired;
        src[`OTGC_SRC_SE0_IDLE] = se0_if.expired;
        src[`OTGC_SRC_B_SESSION_ENDED] = b_session_ended;
        src[`OTGC_SRC_REMOTE_CONNECT_SEEN] = remote_connect_seen;
        src[`OTGC_SRC_ID] = id_pin;
        src[`OTGC_SRC_P1_DP] = port1_plus_line_state;
        src[`OTGC_SRC_P1_SESS] = sess_valid;
        src[`OTGC_SRC_P1_VBUS] = port1_bus_power_valid;
        nxt_st.src = src;

        // read data stands for the one cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `OTGC_ADDR_CTRL_SET, `OTGC_ADDR_CTRL_CLR: nxt_st.rdata = st_ff.ctrl;
                `OTGC_ADDR_SRC: nxt_st.rdata = st_ff.src;
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '{ctrl: `OTGC_CTL_RESET, src: `OTGC_SRC_RESET, rdata: '0,
                       br_state: OTGC_BR_IDLE, br_cnt: '0, rmt_prev: 1'b0,
                       port1_power: 1'b0, bdis_event: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign controller_select = st_ff.ctrl[`OTGC_CTL_CTRL_SEL];
    assign bus_reset_drive = (st_ff.br_state == OTGC_BR_DRIVE);
    assign bus_power_charge = st_ff.ctrl[`OTGC_CTL_CHARGE];
    assign bus_power_discharge = st_ff.ctrl[`OTGC_CTL_DISCHARGE];
    assign port1_power_drive = st_ff.port1_power;
    assign minus_line_pull_down = st_ff.ctrl[`OTGC_CTL_DM_PD];
    assign plus_line_pull_down = st_ff.ctrl[`OTGC_CTL_DP_PD];
    assign plus_line_pull_up = st_ff.ctrl[`OTGC_CTL_DP_PU];
    assign b_disconnect_a_connect_event = st_ff.bdis_event;
endmodule : otgc_control

// *** otgc_control_chk.sv ***
// otgc_control_chk: timing relations on the otgc_control ports
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ps
module otgc_control_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic otg_mode,
    input wire logic hub_port1_power,
    input wire logic remote_connect_seen,
    input wire logic controller_select,
    input wire logic bus_reset_drive,
    input wire logic port1_power_drive,
    input wire logic plus_line_pull_up,
    input wire logic b_disconnect_a_connect_event
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence conn_rise;
        !remote_connect_seen ##1 remote_connect_seen;
    endsequence
    set_pullup_a: assert property (
        reg_wr && reg_addr == 8'he4 && reg_wdata[0] |=> plus_line_pull_up)
        else $error("pull-up not set");
    clr_pullup_a: assert property (
        reg_wr && reg_addr == 8'he6 && reg_wdata[0] && $stable(remote_connect_seen)
        |=> !plus_line_pull_up) else $error("pull-up not cleared");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 16'h0000) else $error("read data without read");
    conn_refuse_a: assert property (
        conn_rise ##0 controller_select |=> !bus_reset_drive)
        else $error("bus reset while peripheral selected");
    reset_start_a: assert property (
        $rose(bus_reset_drive) |-> $past(remote_connect_seen) && !$past(remote_connect_seen, 2))
        else $error("bus reset without connect");
    reset_end_a: assert property (
        bus_reset_drive && !remote_connect_seen |=> !bus_reset_drive)
        else $error("bus reset outlives connect");
    event_bits_a: assert property (
        b_disconnect_a_connect_event |-> controller_select && plus_line_pull_up
        && $past(remote_connect_seen, 2) && !$past(remote_connect_seen))
        else $error("bad disconnect event");
    power_follow_a: assert property (
        !otg_mode |=> port1_power_drive == $past(hub_port1_power))
        else $error("port power ignores hub");
endmodule : otgc_control_chk
bind otgc_control otgc_control_chk otgc_control_chk_i (.*);

// *** otgc_line_model.sv ***
// otgc_line_model: transceiver lines and remote device levels
// assumes the bench sets one pattern bit per source field
`timescale 1ns/1ps
module otgc_line_model (
    input wire logic [15:0] pat,
    output logic remote_connect_seen,
    output logic line_se0,
    output logic b_idle,
    output logic port2_plus_line_state,
    output logic port2_a_session_valid,
    output logic otg_timer_expired,
    output logic b_session_ended,
    output logic id_pin,
    output logic port1_plus_line_state,
    output logic port1_a_session_valid,
    output logic port1_b_session_valid,
    output logic port1_bus_power_valid
);
    assign {b_idle, line_se0} = pat[14:13];
    assign {port2_plus_line_state, port2_a_session_valid, otg_timer_expired} = pat[11:9];
    assign b_session_ended = pat[7];
    // spare pattern bit carries the b-side session level
    assign port1_b_session_valid = pat[5];
    assign {remote_connect_seen, id_pin, port1_plus_line_state} = pat[4:2];
    assign {port1_a_session_valid, port1_bus_power_valid} = pat[1:0];
endmodule : otgc_line_model

// *** otgc_control_tb.sv ***
// otgc_control_tb: register and pin tests of otgc_control
// assumes short timer counts of 8 cycles
`timescale 1ns/1ps
module otgc_control_tb;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, otg_mode = 1, hub_port1_power = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, c, pat = 16'h6088;
    logic remote_connect_seen, line_se0, b_idle, port2_plus_line_state;
    logic port2_a_session_valid, otg_timer_expired, b_session_ended, id_pin;
    logic port1_plus_line_state, port1_a_session_valid, port1_b_session_valid;
    logic port1_bus_power_valid, controller_select, bus_reset_drive, bus_power_charge;
    logic bus_power_discharge, port1_power_drive, minus_line_pull_down;
    logic plus_line_pull_down, plus_line_pull_up, b_disconnect_a_connect_event, seen;
    logic [6:0] outs;
    int errors = 0, comparisons = 0, cyc = 0;
    assign outs = {controller_select, bus_power_charge, bus_power_discharge,
        port1_power_drive, minus_line_pull_down, plus_line_pull_down, plus_line_pull_up};
    always #10 clock = ~clock;
    otgc_control #(.SE0_IDLE_CYCLES(8), .BUS_RESET_CYCLES(8)) otgc_control_i (.*);
    otgc_line_model otgc_line_model_i (.*);
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge clock);
    endtask : rd
    task print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // expected source word from the line pattern and the idle se0 flag
    function automatic logic [15:0] src(input logic [15:0] p, input logic s);
        return {4'h1, p[11:9], s, p[7], 2'b00, p[4:2], p[3] ? p[5] : p[1], p[0]};
    endfunction : src
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(8'he8, 16'h1188);
        rd(8'he4, 16'h0086);
        rd(8'h00, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            c = (16'h0001 << i) & 16'h03f7;
            wr(8'he6, 16'hffff);
            wr(8'he4, 16'h0001 << i);
            rd(8'he6, c);
            check({9'h000, outs}, {9'h000, c[7:4], c[2:0]});
        end
        wr(8'he8, 16'hffff);
        rd(8'he8, 16'h1188);
        wr(8'he4, 16'h0001);
        rd(8'he4, 16'h0201);
        for (int i = 0; i < 17; i++) begin
            pat <= (i < 16) ? 16'h0001 << i : 16'h0028;
            repeat (3) @(posedge clock);
            rd(8'he8, src(pat, 1'b0));
        end
        pat <= 16'h6000;
        repeat (7) @(posedge clock);
        rd(8'he8, src(pat, 1'b0));
        repeat (10) @(posedge clock);
        rd(8'he8, src(pat, 1'b1));
        wr(8'he6, 16'h0001);
        wr(8'he4, 16'h0200);
        wr(8'he6, 16'h0080);
        rd(8'he6, 16'h0200);
        pat <= 16'h0010;
        @(posedge clock);
        #1 check(16'(bus_reset_drive), 16'h0001);
        repeat (7) @(posedge clock);
        #1 check(16'(bus_reset_drive), 16'h0001);
        @(posedge clock);
        #1 check(16'(bus_reset_drive), 16'h0000);
        pat <= 16'h0000;
        wr(8'he6, 16'h0200);
        pat <= 16'h0010;
        repeat (3) @(posedge clock);
        #1 check(16'(bus_reset_drive), 16'h0000);
        wr(8'he4, 16'h0100);
        pat <= 16'h0000;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clock);
            #1 seen = seen | b_disconnect_a_connect_event;
        end
        check(16'(seen), 16'h0001);
        check({9'h000, outs}, 16'h0041);
        rd(8'he4, 16'h0181);
        wr(8'he4, 16'h0200);
        pat <= 16'h0010;
        repeat (3) @(posedge clock);
        #1 check(16'(bus_reset_drive), 16'h0000);
        otg_mode <= 1'b0;
        hub_port1_power <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check(16'(port1_power_drive), 16'h0001);
        print_verdict();
    end
endmodule : otgc_control_tb
